// ===== aci_map.svh
// Purpose: register map, character codes, config fields, reset values
// Assumes: 32-bit AXI4-Lite data, each register one aligned word
// Notes:   definitions only; included by bare name
`ifndef ACI_MAP_SVH
`define ACI_MAP_SVH
`define ACI_A_HOST_CHAR 8'h00
`define ACI_A_RESP      8'h04
`define ACI_A_CONFIG    8'h08
`define ACI_A_STATUS    8'h0c
`define ACI_A_BUFLINES  8'h10
`define ACI_C_ACK       8'h06
`define ACI_C_BELL      8'h07
`define ACI_C_LF        8'h0a
`define ACI_C_CR        8'h0d
`define ACI_C_CTLZ      8'h1a
`define ACI_C_CMIN      8'h01
`define ACI_C_CMAX      8'h1f
`define ACI_C_PMIN      8'h20
`define ACI_C_PMAX      8'h7e
`define ACI_SEL_MIN     4'h1
`define ACI_SEL_MAX     4'h8
`define ACI_N_PROG      10'h100
`define ACI_N_LOGIC     10'h020
`define ACI_ERR_TXT     "ERR005"
`define ACI_CFG_ACK     1:0
`define ACI_CFG_ERR     3:2
`define ACI_CFG_FMT     7:4
`define ACI_CFG_INT     11:8
`define ACI_CFG_B0      7:0
`define ACI_CFG_B1      11:8
`define ACI_CFG_ACK_LF  0
`define ACI_CFG_ERR_ON  2
`define ACI_FMT_HEX     4
`define ACI_FMT_FULL    5
`define ACI_CFG_RST     12'h001
`define ACI_RESP_OK     2'h0
`define ACI_RESP_ERR    2'h2
`endif

// ===== aci_pkg.sv
// Purpose: types shared by the command interpreter modules
// Assumes: constants live in aci_map.svh
// Notes:   top state is one packed struct
package aci_pkg;
	typedef enum logic {ACI_ST_IDLE = 1'h0, ACI_ST_SEND = 1'h1} aci_state_t;
	typedef enum logic {ACI_PORT_SER = 1'h0, ACI_PORT_BUS = 1'h1} aci_port_t;
	typedef enum logic [1:0] {
		ACI_BK_PROG  = 2'h0,
		ACI_BK_ROT   = 2'h1,
		ACI_BK_LOGIC = 2'h2
	} aci_bkind_t;
	typedef enum logic [1:0] {
		ACI_SC_GLOBAL = 2'h0,
		ACI_SC_MOTOR  = 2'h1,
		ACI_SC_CS     = 2'h2
	} aci_scope_t;
	typedef struct packed {
		aci_state_t      st;
		aci_port_t       port;
		logic [11:0]     cfg;
		logic [3:0]      motor;
		logic [3:0]      cs;
		logic [3:0]      pmotor;
		logic [3:0]      pcs;
		logic            bopen;
		logic            bjust;
		aci_bkind_t      bkind;
		logic [7:0]      bnum;
		logic [15:0]     blines;
		logic [7:0][7:0] obuf;
		logic [3:0]      olen;
		logic [3:0]      oidx;
		logic            exec_v;
		logic [7:0]      exec_code;
		aci_scope_t      exec_scope;
		logic [3:0]      exec_motor;
		logic [3:0]      exec_cs;
		logic            app_v;
		logic            clr_v;
		logic            ctrl_v;
		logic [7:0]      ctrl_code;
		logic            ser_rdy;
		logic            awrdy;
		logic            bvalid;
		logic [1:0]      bresp;
		logic            arrdy;
		logic            rvalid;
		logic [1:0]      rresp;
		logic [31:0]     rdata;
	} aci_top_st_t;
endpackage

// ===== aci_chr_if.sv
// Purpose: one-character valid/ready carrier between block modules
// Assumes: both ends on aclk
// Notes:   a character moves when valid and ready are both high
`timescale 1ns/1ps
interface aci_chr_if;
	logic       valid;
	logic       ready;
	logic [7:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ===== aci_line_queue.sv
// Purpose: holds the printable text of the line being typed
// Assumes: clr and push never meet a full queue in a useful way
// Notes:   a full queue drops characters; the line decodes truncated
`timescale 1ns/1ps
module aci_line_queue #(
	parameter int DEPTH = 32,
	parameter int PEEK  = 5,
	parameter int QW    = $clog2(DEPTH + 1)
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             ce,
	aci_chr_if.snk                push,
	input  wire logic             clr,
	output logic [QW-1:0]         count,
	output logic [PEEK-1:0][7:0]  peek
);
	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem;
		logic [QW-1:0]         cnt;
	} aci_lq_st_t;

	aci_lq_st_t s;
	aci_lq_st_t next_s;

	// clear wins: a line end never carries a character of its own
	always_comb begin
		next_s = s;
		if (clr) begin
			next_s.cnt = '0;
		end else if (push.valid && push.ready) begin
			next_s.mem[s.cnt] = push.data;
			next_s.cnt = s.cnt + QW'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign push.ready = (s.cnt != QW'(DEPTH));
	assign count = s.cnt;

	// first characters of the line are visible for decoding
	for (genvar g = 0; g < PEEK; g++) begin : g_peek
		assign peek[g] = s.mem[g];
	end
endmodule

// ===== aci_resp_tx.sv
// Purpose: one-byte response stage steered to serial or bus port
// Assumes: to_bus is stable while a byte is accepted
// Notes:   destination latched with the byte, so a port change
//          never splits a byte; one byte in flight at most
`timescale 1ns/1ps
module aci_resp_tx (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       ce,
	aci_chr_if.snk          src,
	input  wire logic       to_bus,
	input  wire logic       ser_ready,
	input  wire logic       bus_pop,
	output logic            ser_v,
	output logic [7:0]      ser_c,
	output logic            bus_v,
	output logic [7:0]      bus_c
);
	typedef struct packed {
		logic       ser_v;
		logic       bus_v;
		logic [7:0] c;
	} aci_rt_st_t;

	aci_rt_st_t s;
	aci_rt_st_t next_s;

	// drain on the port handshake, refill from the sequencer
	always_comb begin
		next_s = s;
		if (s.ser_v && ser_ready) begin
			next_s.ser_v = 1'h0;
		end
		if (s.bus_v && bus_pop) begin
			next_s.bus_v = 1'h0;
		end
		if (src.valid && src.ready) begin
			next_s.c = src.data;
			next_s.ser_v = !to_bus;
			next_s.bus_v = to_bus;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign src.ready = !(s.ser_v || s.bus_v);
	assign ser_v = s.ser_v;
	assign ser_c = s.c;
	assign bus_v = s.bus_v;
	assign bus_c = s.c;
endmodule

// ===== aci_top.sv
// Purpose: ASCII command interpreter front end with AXI4-Lite port
// Assumes: serial characters come from a receiver on aclk
// Notes:   one command per line; motion itself happens outside
`timescale 1ns/1ps
`include "aci_map.svh"
module aci_top #(
	parameter int QDEPTH = 32
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [7:0]  awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [7:0]  araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	input  wire logic        ser_rx_valid,
	input  wire logic [7:0]  ser_rx_char,
	output logic             ser_rx_ready,
	output logic             ser_tx_valid,
	output logic [7:0]       ser_tx_char,
	input  wire logic        ser_tx_ready,
	input  wire logic        prog_sel_valid,
	input  wire logic        prog_sel_cs,
	input  wire logic [3:0]  prog_sel_num,
	output logic             exec_valid,
	output logic [7:0]       exec_code,
	output logic [1:0]       exec_scope,
	output logic [3:0]       exec_motor,
	output logic [3:0]       exec_cs,
	output logic             buf_append,
	output logic             buf_clear,
	output logic             buf_open,
	output logic [1:0]       buf_kind,
	output logic [7:0]       buf_num,
	output logic             ctrl_valid,
	output logic [7:0]       ctrl_code,
	output logic             resp_port
);
	localparam int QW = $clog2(QDEPTH + 1);
	localparam int PEEK = 5;
	localparam logic [47:0] ERR_TXT = `ACI_ERR_TXT;

	aci_pkg::aci_top_st_t s;
	aci_pkg::aci_top_st_t next_s;
	aci_chr_if q_if ();
	aci_chr_if o_if ();
	logic [QW-1:0]         qn;
	logic [PEEK-1:0][7:0]  p;
	logic                  qclr;
	logic                  bus_pop;
	logic                  rb_v;
	logic [7:0]            rb_c;

	function automatic logic isd(input logic [7:0] ch);
		isd = (ch >= "0") && (ch <= "9");
	endfunction

	function automatic logic [3:0] dv(input logic [7:0] ch);
		dv = 4'(ch - "0");
	endfunction

	function automatic logic selok(input logic [7:0] ch);
		selok = isd(ch) && (dv(ch) >= `ACI_SEL_MIN)
			&& (dv(ch) <= `ACI_SEL_MAX);
	endfunction

	function automatic logic [7:0] hexc(input logic [3:0] v);
		hexc = (v < 4'ha) ? 8'("0" + v) : 8'("A" + v - 4'ha);
	endfunction

	aci_line_queue #(
		.DEPTH (QDEPTH),
		.PEEK  (PEEK),
		.QW    (QW)
	) u_queue (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.push    (q_if),
		.clr     (qclr),
		.count   (qn),
		.peek    (p)
	);

	aci_resp_tx u_tx (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.ce        (ce),
		.src       (o_if),
		.to_bus    (s.port == aci_pkg::ACI_PORT_BUS),
		.ser_ready (ser_tx_ready),
		.bus_pop   (bus_pop),
		.ser_v     (ser_tx_valid),
		.ser_c     (ser_tx_char),
		.bus_v     (rb_v),
		.bus_c     (rb_c)
	);

	// interpreter, response builder and register slave in one pass
	always_comb begin
		logic [7:0]      c;
		logic [7:0]      rn;
		logic [7:0]      ackc;
		logic [7:0][7:0] ob;
		logic [3:0]      k;
		logic [9:0]      num;
		logic            cv;
		logic            tbus;
		logic            trd;
		logic            ok;
		logic            err5;
		logic            dat;
		logic            app;
		logic            exe;
		logic            numok;
		aci_pkg::aci_scope_t sc;
		c = '0;
		rn = '0;
		ackc = '0;
		ob = '0;
		k = '0;
		num = '0;
		cv = 1'h0;
		ok = 1'h0;
		err5 = 1'h0;
		dat = 1'h0;
		app = 1'h0;
		exe = 1'h0;
		numok = 1'h0;
		sc = aci_pkg::ACI_SC_GLOBAL;
		next_s = s;
		next_s.exec_v = 1'h0;
		next_s.app_v = 1'h0;
		next_s.clr_v = 1'h0;
		next_s.ctrl_v = 1'h0;
		tbus = ce && s.awrdy && awvalid && wvalid;
		trd = ce && s.arrdy && arvalid;

		// character intake; the two ports never get ready together
		if (tbus && awaddr == `ACI_A_HOST_CHAR && wstrb[0]) begin
			cv = 1'h1;
			c = wdata[7:0];
			next_s.port = aci_pkg::ACI_PORT_BUS;
		end else if (ce && s.ser_rdy && ser_rx_valid) begin
			cv = 1'h1;
			c = ser_rx_char;
		end
		q_if.valid = cv && c >= `ACI_C_PMIN && c <= `ACI_C_PMAX;
		q_if.data = c;
		qclr = cv && c == `ACI_C_CR;

		// control codes act at once and leave the line alone
		if (cv && c >= `ACI_C_CMIN && c <= `ACI_C_CMAX
			&& c != `ACI_C_CR) begin
			next_s.ctrl_v = 1'h1;
			next_s.ctrl_code = c;
			if (c == `ACI_C_CTLZ) begin
				next_s.port = aci_pkg::ACI_PORT_SER;
			end
		end

		// number after an open of a program or logic buffer
		numok = isd(p[2]);
		if (qn == QW'(3)) begin
			num = 10'(dv(p[2]));
		end else if (qn == QW'(4)) begin
			numok = numok && isd(p[3]);
			num = 10'(dv(p[2])) * 10'h00a + 10'(dv(p[3]));
		end else if (qn == QW'(5)) begin
			numok = numok && isd(p[3]) && isd(p[4]);
			num = 10'(dv(p[2])) * 10'h064
				+ 10'(dv(p[3])) * 10'h00a + 10'(dv(p[4]));
		end else begin
			numok = 1'h0;
		end

		// a line end decodes the queued text
		if (qclr && qn != '0) begin
			case (p[0])
			"#": begin
				if (qn == QW'(2) && selok(p[1])) begin
					ok = 1'h1;
					next_s.motor = dv(p[1]);
				end
			end
			"&": begin
				if (qn == QW'(2) && selok(p[1])) begin
					ok = 1'h1;
					next_s.cs = dv(p[1]);
				end
			end
			"O": begin
				if (!s.bopen) begin
					if (p[1] == "R" && qn == QW'(2)) begin
						ok = 1'h1;
						next_s.bkind = aci_pkg::ACI_BK_ROT;
						next_s.bnum = {4'h0, s.cs - 4'h1};
					end else if (p[1] == "P" && numok
						&& num < `ACI_N_PROG) begin
						ok = 1'h1;
						next_s.bkind = aci_pkg::ACI_BK_PROG;
						next_s.bnum = num[7:0];
					end else if (p[1] == "L" && numok
						&& num < `ACI_N_LOGIC) begin
						ok = 1'h1;
						next_s.bkind = aci_pkg::ACI_BK_LOGIC;
						next_s.bnum = num[7:0];
					end
					if (ok) begin
						next_s.bopen = 1'h1;
						next_s.bjust = 1'h1;
						next_s.blines = '0;
					end
				end
			end
			"C": begin
				if (s.bopen && qn == QW'(5) && p[1] == "L") begin
					if (p[2] == "E" && s.bjust) begin
						ok = 1'h1;
						next_s.clr_v = 1'h1;
					end else if (p[2] == "O") begin
						ok = 1'h1;
						next_s.bopen = 1'h0;
						next_s.bjust = 1'h0;
					end
				end
			end
			"X", "Y", "Z": begin
				app = s.bopen;
				err5 = !s.bopen;
			end
			"J": begin
				exe = 1'h1;
				sc = aci_pkg::ACI_SC_MOTOR;
			end
			"P", "I", "M": begin
				app = s.bopen;
				exe = !s.bopen;
			end
			"Q": begin
				app = s.bopen;
				exe = !s.bopen;
				sc = aci_pkg::ACI_SC_CS;
			end
			"?": begin
				ok = 1'h1;
				dat = 1'h1;
			end
			default: begin
				ok = 1'h0;
			end
			endcase

			// appended lines land at the end of the open buffer
			if (app) begin
				ok = 1'h1;
				next_s.app_v = 1'h1;
				next_s.bjust = 1'h0;
				next_s.blines = s.blines + 16'h0001;
			end
			// executed lines leave only their effect behind
			if (exe) begin
				ok = 1'h1;
				next_s.exec_v = 1'h1;
				next_s.exec_code = p[0];
				next_s.exec_scope = sc;
				next_s.exec_motor = s.motor;
				next_s.exec_cs = s.cs;
			end

			// build the answer bytes in send order
			ackc = (s.cfg[`ACI_CFG_ACK] == 2'h1) ? `ACI_C_LF
				: `ACI_C_ACK;
			rn = s.bopen ? s.bnum : 8'h00;
			if (!ok) begin
				ob[k] = `ACI_C_BELL;
				k = k + 4'h1;
				if (err5 && s.cfg[`ACI_CFG_ERR_ON]) begin
					for (int i = 5; i >= 0; i--) begin
						ob[k] = ERR_TXT[i*8 +: 8];
						k = k + 4'h1;
					end
					ob[k] = `ACI_C_CR;
					k = k + 4'h1;
				end
			end else begin
				if (dat) begin
					if (s.cfg[`ACI_CFG_ACK_LF]) begin
						ob[k] = `ACI_C_LF;
						k = k + 4'h1;
					end
					if (s.cfg[`ACI_FMT_FULL]) begin
						ob[k] = "B";
						k = k + 4'h1;
					end
					if (s.cfg[`ACI_FMT_HEX]) begin
						ob[k] = hexc(rn[7:4]);
						ob[k + 4'h1] = hexc(rn[3:0]);
						k = k + 4'h2;
					end else begin
						ob[k] = 8'("0" + rn / 8'h64);
						ob[k + 4'h1] = 8'("0" + (rn / 8'h0a) % 8'h0a);
						ob[k + 4'h2] = 8'("0" + rn % 8'h0a);
						k = k + 4'h3;
					end
					ob[k] = `ACI_C_CR;
					k = k + 4'h1;
				end
				if (s.cfg[`ACI_CFG_ACK] != 2'h0) begin
					ob[k] = ackc;
					k = k + 4'h1;
				end
			end
			next_s.obuf = ob;
			next_s.olen = k;
			next_s.oidx = '0;
			if (k != 4'h0) begin
				next_s.st = aci_pkg::ACI_ST_SEND;
			end
		end

		// response bytes leave one at a time
		o_if.valid = (s.st == aci_pkg::ACI_ST_SEND);
		o_if.data = s.obuf[s.oidx];
		unique case (s.st)
		aci_pkg::ACI_ST_IDLE: begin
		end
		aci_pkg::ACI_ST_SEND: begin
			if (ce && o_if.ready) begin
				next_s.oidx = s.oidx + 4'h1;
				if (s.oidx + 4'h1 == s.olen) begin
					next_s.st = aci_pkg::ACI_ST_IDLE;
				end
			end
		end
		endcase

		// host-program selections only touch the program's copy
		if (ce && prog_sel_valid && selok(8'("0" + prog_sel_num))) begin
			if (prog_sel_cs) begin
				next_s.pcs = prog_sel_num;
			end else begin
				next_s.pmotor = prog_sel_num;
			end
		end

		// write channel: address and data taken together
		if (ce && s.bvalid && bready) begin
			next_s.bvalid = 1'h0;
		end
		if (tbus) begin
			next_s.bvalid = 1'h1;
			next_s.bresp = `ACI_RESP_OK;
			case (awaddr)
			`ACI_A_HOST_CHAR: begin
			end
			`ACI_A_CONFIG: begin
				if (wstrb[0]) begin
					next_s.cfg[`ACI_CFG_B0] = wdata[`ACI_CFG_B0];
				end
				if (wstrb[1]) begin
					next_s.cfg[`ACI_CFG_B1] = wdata[`ACI_CFG_B1];
				end
			end
			default: begin
				next_s.bresp = `ACI_RESP_ERR;
			end
			endcase
		end

		// read channel; reading the response register pops it
		bus_pop = 1'h0;
		if (ce && s.rvalid && rready) begin
			next_s.rvalid = 1'h0;
		end
		if (trd) begin
			next_s.rvalid = 1'h1;
			next_s.rresp = `ACI_RESP_OK;
			next_s.rdata = '0;
			case (araddr)
			`ACI_A_HOST_CHAR: begin
			end
			`ACI_A_RESP: begin
				next_s.rdata = {23'h00_0000, rb_v, rb_c};
				bus_pop = rb_v;
			end
			`ACI_A_CONFIG: begin
				next_s.rdata = {20'h0_0000, s.cfg};
			end
			`ACI_A_STATUS: begin
				next_s.rdata = {s.bnum, 3'h0, s.st, s.port, s.bkind,
					s.bopen, s.pcs, s.pmotor, s.cs, s.motor};
			end
			`ACI_A_BUFLINES: begin
				next_s.rdata = {16'h0000, s.blines};
			end
			default: begin
				next_s.rresp = `ACI_RESP_ERR;
			end
			endcase
		end

		// write and serial readies drop while an answer is being sent; arready does not
		next_s.awrdy = (next_s.st == aci_pkg::ACI_ST_IDLE) && awvalid
			&& wvalid && !s.awrdy && !next_s.bvalid;
		next_s.ser_rdy = (next_s.st == aci_pkg::ACI_ST_IDLE)
			&& !(awvalid && wvalid) && !s.awrdy;
		next_s.arrdy = arvalid && !s.arrdy && !next_s.rvalid;
	end

	// reset selects motor 1, coordinate system 1, serial answers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.cfg <= `ACI_CFG_RST;
			s.motor <= `ACI_SEL_MIN;
			s.cs <= `ACI_SEL_MIN;
			s.pmotor <= `ACI_SEL_MIN;
			s.pcs <= `ACI_SEL_MIN;
			s.port <= aci_pkg::ACI_PORT_SER;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign awready = s.awrdy;
	assign wready = s.awrdy;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arrdy;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign ser_rx_ready = s.ser_rdy;
	assign exec_valid = s.exec_v;
	assign exec_code = s.exec_code;
	assign exec_scope = s.exec_scope;
	assign exec_motor = s.exec_motor;
	assign exec_cs = s.exec_cs;
	assign buf_append = s.app_v;
	assign buf_clear = s.clr_v;
	assign buf_open = s.bopen;
	assign buf_kind = s.bkind;
	assign buf_num = s.bnum;
	assign ctrl_valid = s.ctrl_v;
	assign ctrl_code = s.ctrl_code;
	assign resp_port = s.port;
endmodule

// ===== aci_top_checker.sv
// Purpose: port-level checks on the command interpreter top
// Assumes: one clock, synchronous active-low reset
// Notes:   attached by bind from the bench top file
`timescale 1ns/1ps
module aci_top_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic [7:0]  awaddr,
	input wire logic        wvalid,
	input wire logic [31:0] wdata,
	input wire logic [3:0]  wstrb,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        ser_rx_valid,
	input wire logic [7:0]  ser_rx_char,
	input wire logic        ser_rx_ready,
	input wire logic        ser_tx_valid,
	input wire logic [7:0]  ser_tx_char,
	input wire logic        ser_tx_ready,
	input wire logic        exec_valid,
	input wire logic [3:0]  exec_motor,
	input wire logic [3:0]  exec_cs,
	input wire logic        buf_append,
	input wire logic        buf_open,
	input wire logic        ctrl_valid,
	input wire logic [7:0]  ctrl_code,
	input wire logic        resp_port
);
	logic rx_take;
	logic wr_take;
	// character takes from either port; bus only counts at host char
	assign rx_take = ser_rx_valid && ser_rx_ready;
	assign wr_take = awvalid && awready && wvalid && awaddr == 8'h00;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_ctlz_in;
		rx_take && ser_rx_char == 8'h1a;
	endsequence
	sequence s_serial_back;
		!resp_port && ctrl_valid && ctrl_code == 8'h1a;
	endsequence
	property p_exec_cause;
		exec_valid |-> $past((rx_take && ser_rx_char == 8'h0d) ||
			(wr_take && wdata[7:0] == 8'h0d));
	endproperty
	property p_ctrl_cause;
		ctrl_valid |-> ctrl_code inside {[8'h01:8'h1f]} &&
			ctrl_code != 8'h0d && ($past(rx_take) &&
			$past(ser_rx_char) == ctrl_code || $past(wr_take) &&
			$past(wdata[7:0]) == ctrl_code);
	endproperty
	// pulses come only from the take one cycle before
	property p_quiet;
		rx_take && ser_rx_char inside {[8'h20:8'h7e]} |=>
			!exec_valid && !ctrl_valid && !buf_append;
	endproperty
	property p_ctlz;
		s_ctlz_in |=> s_serial_back;
	endproperty
	property p_bus_port;
		wr_take && wstrb[0] && wdata[7:0] != 8'h1a |=> resp_port;
	endproperty
	property p_rose_port;
		$rose(resp_port) |-> $past(wr_take);
	endproperty
	property p_sel;
		exec_valid |-> exec_motor inside {[4'h1:4'h8]} &&
			exec_cs inside {[4'h1:4'h8]};
	endproperty
	property p_append;
		buf_append |-> buf_open;
	endproperty
	property p_tx_hold;
		ser_tx_valid && !ser_tx_ready |=> ser_tx_valid && $stable(ser_tx_char);
	endproperty
	property p_b_hold;
		bvalid && !bready |=> bvalid;
	endproperty
	a_exec_cause: assert property (p_exec_cause) else $error("exec without CR");
	a_ctrl_cause: assert property (p_ctrl_cause) else $error("bad ctrl pulse");
	a_quiet: assert property (p_quiet) else $error("printable char acted");
	a_ctlz: assert property (p_ctlz) else $error("ctrl-z not serial");
	a_bus_port: assert property (p_bus_port) else $error("bus not port");
	a_rose_port: assert property (p_rose_port) else $error("port moved");
	a_sel: assert property (p_sel) else $error("selection range");
	a_append: assert property (p_append) else $error("append, none open");
	a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped");
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
endmodule

// ===== aci_host_model.sv
// Purpose: serial host that types command lines and collects replies
// Assumes: one character offered at a time, held until taken
// Notes:   idle data line toggles every cycle between the last character and its inverse
`timescale 1ns/1ps
module aci_host_model (
	input wire logic        aclk,
	output logic            rx_valid,
	output logic [7:0]      rx_char,
	input wire logic        rx_ready,
	input wire logic        tx_valid,
	input wire logic [7:0]  tx_char,
	output logic            tx_ready
);
	logic [7:0] txq[$];
	logic [7:0] got[$];
	bit         slow = 1'b1;
	int         cyc = 0;
	initial begin
		rx_valid = 1'b0;
		rx_char = 8'h00;
		tx_ready = 1'b0;
	end
	// hold an offered character until taken; replies taken slowly
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (tx_valid === 1'b1 && tx_ready) got.push_back(tx_char);
		if (!(rx_valid && rx_ready !== 1'b1)) begin
			if (txq.size() != 0) begin
				rx_valid <= 1'b1;
				rx_char <= txq.pop_front();
			end else begin
				rx_valid <= 1'b0;
				rx_char <= ~rx_char;
			end
		end
		tx_ready <= !slow || (cyc % 3 == 0);
	end
	task automatic send(input string s);
		foreach (s[i]) txq.push_back(s[i]);
	endtask
endmodule

// ===== aci_top_tb_top.sv
// Purpose: self-checking bench for the command interpreter
// Assumes: serial host model on the rx/tx pair, bench drives the bus
// Notes:   clock enable held high throughout
`timescale 1ns/1ps
`include "aci_map.svh"
module aci_top_tb_top;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        ce = 1'b1;
	logic        awvalid, wvalid, bready, arvalid, rready, prog_sel_valid;
	logic        prog_sel_cs;
	logic [3:0]  prog_sel_num;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, d;
	logic [1:0]  r;
	logic [7:0]  last_ctrl = 8'h00;
	logic [17:0] last_exec = 18'h0_0000;
	int          err_total = 0;
	int          comparisons = 0;
	int          cycles = 0;
	int          n_app = 0;
	int          n_clr = 0;
	string       acks[4] = '{"", "\012", "\006", "\006"};
	wire logic        awready, wready, bvalid, rvalid, ser_rx_valid;
	wire logic        ser_rx_ready, ser_tx_valid, ser_tx_ready, exec_valid;
	wire logic        buf_append, buf_clear, buf_open, ctrl_valid, resp_port;
	wire logic [1:0]  bresp, rresp, exec_scope, buf_kind;
	wire logic [31:0] rdata;
	wire logic [7:0]  ser_rx_char, ser_tx_char, exec_code, buf_num, ctrl_code;
	wire logic [3:0]  exec_motor, exec_cs;
	wire logic        arready;
	logic [3:0]  wstrb = 4'hf;
	aci_top dut_u (.aclk, .aresetn, .ce, .awvalid, .awready, .awaddr,
		.wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
		.arready, .araddr, .rvalid, .rready, .rdata, .rresp, .ser_rx_valid,
		.ser_rx_char, .ser_rx_ready, .ser_tx_valid, .ser_tx_char,
		.ser_tx_ready, .prog_sel_valid, .prog_sel_cs, .prog_sel_num,
		.exec_valid, .exec_code, .exec_scope, .exec_motor, .exec_cs,
		.buf_append, .buf_clear, .buf_open, .buf_kind, .buf_num, .ctrl_valid,
		.ctrl_code, .resp_port);
	aci_host_model host_u (.aclk(aclk), .rx_valid(ser_rx_valid),
		.rx_char(ser_rx_char), .rx_ready(ser_rx_ready),
		.tx_valid(ser_tx_valid), .tx_char(ser_tx_char),
		.tx_ready(ser_tx_ready));
	always #5 aclk = ~aclk;
	// pulse tallies and the cycle ceiling that cuts a hang short
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (buf_append === 1'b1) n_app <= n_app + 1;
		if (buf_clear === 1'b1) n_clr <= n_clr + 1;
		if (ctrl_valid === 1'b1) last_ctrl <= ctrl_code;
		if (exec_valid === 1'b1)
			last_exec <= {exec_code, exec_scope, exec_motor, exec_cs};
		if (cycles == 30000) begin
			err_total++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do @(posedge aclk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	// type a line, then wait for the reply and compare it byte by byte
	task automatic line(input string s, input string e);
		int i;
		host_u.send(s);
		for (i = 0; i < 3000 && host_u.got.size() < e.len(); i++)
			@(posedge aclk);
		repeat (30) @(posedge aclk);
		check(host_u.got.size(), e.len());
		for (i = 0; i < e.len() && i < host_u.got.size(); i++)
			check(host_u.got[i], e[i]);
		host_u.got.delete();
	endtask
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, prog_sel_valid} = '0;
		{awaddr, araddr, wdata, prog_sel_cs, prog_sel_num} = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`ACI_A_CONFIG);
		check(d, 32'h0000_0001);
		rd(`ACI_A_STATUS);
		check(d[19:0], 20'h0_1111);
		line("#2\015", "\012");
		line("#\0025\015", "\012");
		check(last_ctrl, 8'h02);
		for (int m = 0; m < 4; m++) begin
			wr(`ACI_A_CONFIG, m);
			line("&3\015", acks[m]);
			line("!\015", "\007");
		end
		wr(`ACI_A_CONFIG, 32'h0000_0007);
		line("X1\015", "\007ERR005\015");
		wr(`ACI_A_CONFIG, 32'h0000_0003);
		line("X1\015", "\007");
		line("?\015", "\012000\015\006");
		wr(`ACI_A_CONFIG, 32'h0000_0032);
		line("?\015", "B00\015\006");
		wr(`ACI_A_CONFIG, 32'h0000_0001);
		line("P1\015", "\012");
		check(n_app, 0);
		line("OP255\015", "\012");
		check({buf_open, buf_kind, buf_num}, 11'h4ff);
		line("CLEAR\015", "\012");
		line("P1\015", "\012");
		line("J1\015", "\012");
		check({n_clr[3:0], n_app[3:0]}, 8'h11);
		check(last_exec, 18'h1_2953);
		line("OP1\015", "\007");
		line("?\015", "\012255\015\012");
		line("CLOSE\015", "\012");
		check(buf_open, 1'b0);
		line("CLEAR\015", "\007");
		line("OL31\015", "\012");
		check({buf_kind, buf_num}, 10'h21f);
		line("CLOSE\015", "\012");
		line("OL32\015", "\007");
		line("OR\015", "\012");
		check({buf_kind, buf_num}, 10'h102);
		line("CLOSE\015", "\012");
		prog_sel_num <= 4'h7;
		prog_sel_valid <= 1'b1;
		@(posedge aclk);
		prog_sel_cs <= 1'b1;
		prog_sel_num <= 4'h4;
		@(posedge aclk);
		prog_sel_valid <= 1'b0;
		line("#8\015", "\012");
		rd(`ACI_A_STATUS);
		check(d[15:0], 16'h4738);
		wr(`ACI_A_STATUS, 32'h0000_0000);
		check(r, `ACI_RESP_ERR);
		rd(8'h40);
		check(r, `ACI_RESP_ERR);
		check(d, 32'h0000_0000);
		wr(`ACI_A_HOST_CHAR, 32'h0000_0023);
		check({r, resp_port}, 3'h1);
		line("\032", "");
		check(resp_port, 1'b0);
		line("6\015", "\012");
		wr(`ACI_A_HOST_CHAR, 32'h0000_0021);
		wr(`ACI_A_HOST_CHAR, 32'h0000_000d);
		rd(`ACI_A_RESP);
		check(d, 32'h0000_0107);
		print_verdict();
	end
endmodule
bind aci_top aci_top_checker chk_u (.aclk, .aresetn, .awvalid, .awready,
	.awaddr, .wvalid, .wdata, .wstrb, .bvalid, .bready, .ser_rx_valid,
	.ser_rx_char, .ser_rx_ready, .ser_tx_valid, .ser_tx_char, .ser_tx_ready,
	.exec_valid, .exec_motor, .exec_cs, .buf_append, .buf_open, .ctrl_valid,
	.ctrl_code, .resp_port);
